// ### verilog/static_mem_ctrl.sv
// Static external memory controller: async mode 1 and sync single accesses, 16-bit memory
// Summary of operation
// - 32-bit host access becomes two 16-bit accesses
// - Refuse NOR byte writes, sync byte reads
// - Page-mode read sequences only in word reads with zero address phase and turnaround
// - Byte writes enable only the addressed lane
// - Sync reads NOR/PSRAM; sync writes PSRAM only
// - All outputs change on host clock edge
// - Sync falling strobes align to clock fall
// - Sync rising strobes align to clock rise
// - Async accesses drive no memory clock
// - Capture read data before output enable rises
// - Extended mode: independent read/write timing sets
// - SRAM/PSRAM without extended mode use mode 1
// - NOR without extended mode uses mode 2
// - Mode 1 write ends with one hold cycle
// - Mode 1 reads keep both lanes low
// - Sync-only fields ignored in async accesses
// - Wait polarity applies only when monitoring
// - Address phase lasts address setup cycles
// - Data phase: reads N, writes N plus one
// - Turnaround gap between selects rising and falling
// - One active-low select per bank, four
`timescale 1ns/10ps
`include "smc_defines.svh"
module static_mem_ctrl
   import smc_pkg::*;
#(
   parameter int ADDR_W = 26
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   // Register port
   input wire logic [`REG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Host requests
   input wire logic host_req,
   input wire logic host_write,
   input wire size_t host_size,
   input wire logic [ADDR_W+2:0] host_addr,
   input wire logic [31:0] host_wdata,
   output logic host_ready,
   output logic host_done,
   output logic host_error,
   output logic [31:0] host_rdata,
   // Memory pins
   output logic [ADDR_W-1:0] mem_addr,
   output logic [15:0] mem_data_out,
   output logic mem_data_oe,
   input wire logic [15:0] mem_data_in,
   input wire logic mem_wait,
   output logic [3:0] bank_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic addr_latch_n,
   output logic [1:0] byte_lane_en_n,
   output logic memory_clock_out
);
   // Lanes for a write: byte picks one lane, wider uses both
   function automatic logic [1:0] write_lanes(input size_t size, input logic odd);
      if (size == SIZE_BYTE) begin
         write_lanes = odd ? 2'h2 : 2'h1;
      end else begin
         write_lanes = 2'h3;
      end
   endfunction : write_lanes

   logic [31:0] bank_control_reg [4];
   logic [31:0] bank_timing_reg [4];
   logic [31:0] bank_write_timing_reg [4];
   state_t state;
   state_t next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [1:0] cur_bank;
   logic [ADDR_W-1:0] cur_addr;
   logic cur_odd;
   logic cur_write;
   size_t cur_size;
   logic cur_half;
   logic [31:0] cur_wdata;
   logic err_flag;
   logic [15:0] data_meta;
   logic [15:0] data_sync;
   logic wait_meta;
   logic wait_sync;
   logic [1:0] sel_bank;
   logic sel_write;
   logic sel_sync;
   logic [31:0] sel_bcr;
   logic [31:0] sel_tim;
   logic req_ok;
   logic accept;
   logic capture;
   logic end_now;
   logic start_half;
   logic next_half;
   logic [ADDR_W-1:0] next_addr;
   logic wait_active;
   logic next_active;
   logic next_strobe;
   access_mode_t cur_mode;
   mem_clk_if mc ();

   // Two-stage synchronisers for memory inputs
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         data_meta <= 16'h0000;
         data_sync <= 16'h0000;
         wait_meta <= 1'b0;
         wait_sync <= 1'b0;
      end else if (clk_en) begin
         data_meta <= mem_data_in;
         data_sync <= data_meta;
         wait_meta <= mem_wait;
         wait_sync <= wait_meta;
      end
   end

   // Configuration of the bank being started or in progress
   assign sel_bank = state[0] ? host_addr[ADDR_W+2:ADDR_W+1] : cur_bank;
   assign sel_write = state[0] ? host_write : cur_write;
   assign sel_bcr = bank_control_reg[sel_bank];
   // Extended mode selects separate write timing
   assign sel_tim = (sel_bcr[`BCR_EXT_EN] && sel_write) ? bank_write_timing_reg[sel_bank]
                                                         : bank_timing_reg[sel_bank];
   // Sync bits matter only for the access type they name
   assign sel_sync = sel_write ? sel_bcr[`BCR_SYNC_WR] : sel_bcr[`BCR_BURST_RD];
   // Wait monitoring honours polarity only when enabled
   assign wait_active = sel_bcr[`BCR_ASYNC_WAIT]
                        && (wait_sync == sel_bcr[`BCR_WAIT_POL]);

   smc_access_check u_check (
      .mem_type(sel_bcr[`BCR_MTYP]),
      .bank_en(sel_bcr[`BCR_BANK_EN]),
      .write_en(sel_bcr[`BCR_WRITE_ALLOW]),
      .sync(sel_sync),
      .write(host_write),
      .size(host_size),
      .allowed(req_ok)
   );

   // Memory clock runs only during sync accesses
   assign mc.ratio = {1'b0, (sel_tim[`BTR_MEM_CLOCK_DIVIDER] < `MEM_CLOCK_DIVIDER_MIN) ? `MEM_CLOCK_DIVIDER_MIN
                                                                : sel_tim[`BTR_MEM_CLOCK_DIVIDER]} + 5'h01;
   assign mc.run = state[4] || state[5];

   smc_clock_div u_div (
      .clock(clock),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .mc(mc)
   );

   // Access sequencer
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      accept = 1'b0;
      capture = 1'b0;
      end_now = 1'b0;
      start_half = 1'b0;
      next_half = cur_half;
      unique case (state)
         S_IDLE: begin
            if (host_req) begin
               accept = 1'b1;
               next_half = 1'b0;
               if (!req_ok) begin
                  next_state = S_DONE;
               end else begin
                  start_half = 1'b1;
               end
            end
         end
         S_ADDR: begin
            if (cnt == 8'h00) begin
               next_state = S_DATA;
               next_cnt = (sel_tim[`BTR_DATA_PHASE_LEN] == 8'h00) ? 8'h00 : sel_tim[`BTR_DATA_PHASE_LEN] - 8'h01;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         S_DATA: begin
            if (wait_active) begin
               next_cnt = cnt;
            end else if (cnt != 8'h00) begin
               next_cnt = cnt - 8'h01;
            end else if (cur_write) begin
               next_state = S_HOLD;
            end else begin
               capture = 1'b1;
               end_now = 1'b1;
            end
         end
         S_HOLD: begin
            end_now = 1'b1;
         end
         S_SYNC_WAIT: begin
            if (mc.fall) begin
               next_state = S_SYNC;
               next_cnt = {4'h0, sel_tim[`BTR_BURST_FIRST_DATA_LATENCY]} + `BURST_FIRST_DATA_LATENCY_BASE;
            end
         end
         S_SYNC: begin
            if (mc.rise) begin
               if (cnt == 8'h01) begin
                  capture = !cur_write;
                  end_now = 1'b1;
               end else begin
                  next_cnt = cnt - 8'h01;
               end
            end
         end
         S_TURN: begin
            if (cnt == 8'h00) begin
               if (cur_size == SIZE_WORD && !cur_half) begin
                  next_half = 1'b1;
                  start_half = 1'b1;
               end else begin
                  next_state = S_DONE;
               end
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         S_DONE: begin
            next_state = S_IDLE;
         end
      endcase
      // End of one memory access: turnaround, next half or done
      if (end_now) begin
         if (sel_tim[`BTR_TURNAROUND_LEN] != 4'h0) begin
            next_state = S_TURN;
            next_cnt = {4'h0, sel_tim[`BTR_TURNAROUND_LEN]} - 8'h01;
         end else if (cur_size == SIZE_WORD && !cur_half) begin
            next_half = 1'b1;
            start_half = 1'b1;
         end else begin
            next_state = S_DONE;
         end
      end
      // Start of one 16-bit access, always a single read or write
      if (start_half) begin
         if (sel_sync) begin
            next_state = S_SYNC_WAIT;
         end else if (sel_tim[`BTR_ADDR_PHASE_LEN] == 4'h0) begin
            next_state = S_DATA;
            next_cnt = (sel_tim[`BTR_DATA_PHASE_LEN] == 8'h00) ? 8'h00 : sel_tim[`BTR_DATA_PHASE_LEN] - 8'h01;
         end else begin
            next_state = S_ADDR;
            next_cnt = {4'h0, sel_tim[`BTR_ADDR_PHASE_LEN]} - 8'h01;
         end
      end
   end

   // Sequencer state
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_IDLE;
         cnt <= 8'h00;
         cur_half <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         cnt <= next_cnt;
         cur_half <= next_half;
      end
   end

   // Latched request
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cur_bank <= 2'h0;
         cur_addr <= '0;
         cur_odd <= 1'b0;
         cur_write <= 1'b0;
         cur_size <= SIZE_BYTE;
         cur_wdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (accept) begin
            cur_bank <= host_addr[ADDR_W+2:ADDR_W+1];
            cur_addr <= host_addr[ADDR_W:1];
            cur_odd <= host_addr[0];
            cur_write <= host_write;
            cur_size <= host_size;
            cur_wdata <= host_wdata;
         end
      end
   end

   // Word address of the half being driven next
   assign next_addr = accept ? host_addr[ADDR_W:1] : (cur_addr + ADDR_W'(next_half));

   // Read data assembly and error result
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         host_rdata <= 32'h0000_0000;
         host_error <= 1'b0;
      end else if (clk_en) begin
         if (accept) begin
            host_rdata <= 32'h0000_0000;
            host_error <= !req_ok;
         end else if (capture) begin
            if (cur_size == SIZE_BYTE) begin
               host_rdata[7:0] <= cur_odd ? data_sync[15:8] : data_sync[7:0];
            end else if (cur_half) begin
               host_rdata[31:16] <= data_sync;
            end else begin
               host_rdata[15:0] <= data_sync;
            end
         end
      end
   end

   // Strobe levels for the state being entered
   assign next_active = next_state[1] || next_state[2] || next_state[3] || next_state[5];
   assign next_strobe = next_state[2] || next_state[5];

   // Memory pins, registered so they move only on the host clock
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mem_addr <= '0;
         mem_data_out <= 16'h0000;
         mem_data_oe <= 1'b0;
         bank_select_n <= 4'hF;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         addr_latch_n <= 1'b1;
         byte_lane_en_n <= 2'h3;
      end else if (clk_en) begin
         if (next_active) begin
            mem_addr <= next_addr;
            bank_select_n <= ~(4'h1 << (accept ? host_addr[ADDR_W+2:ADDR_W+1] : cur_bank));
         end else begin
            bank_select_n <= 4'hF;
         end
         read_strobe_n <= !(next_strobe && !sel_write);
         write_strobe_n <= !(next_strobe && sel_write);
         // Address valid only from the first sync clock fall until the next clock rise
         addr_latch_n <= !(next_state == S_SYNC && next_cnt == ({4'h0, sel_tim[`BTR_BURST_FIRST_DATA_LATENCY]}
                                                               + `BURST_FIRST_DATA_LATENCY_BASE));
         mem_data_oe <= next_active && sel_write;
         // On the accepting edge the request is not latched yet
         if (next_active && sel_write) begin
            if ((accept ? host_size : cur_size) == SIZE_BYTE) begin
               mem_data_out <= accept ? {2{host_wdata[7:0]}} : {2{cur_wdata[7:0]}};
            end else if (accept) begin
               mem_data_out <= host_wdata[15:0];
            end else begin
               mem_data_out <= next_half ? cur_wdata[31:16] : cur_wdata[15:0];
            end
         end
         if (!next_active) begin
            byte_lane_en_n <= 2'h3;
         end else if (!sel_write) begin
            byte_lane_en_n <= 2'h0;
         end else begin
            byte_lane_en_n <= ~write_lanes(accept ? host_size : cur_size,
                                           accept ? host_addr[0] : cur_odd);
         end
      end
   end

   // Clock pin only toggles in sync accesses
   assign memory_clock_out = mc.mem_clk;
   // Host handshake: a new request only when fully idle
   assign host_ready = state == S_IDLE;
   assign host_done = state == S_DONE;

   // Access mode of the bank in progress
   always_comb begin
      if (bank_control_reg[cur_bank][`BCR_EXT_EN]) begin
         cur_mode = access_mode_t'({1'b0, bank_timing_reg[cur_bank][`BTR_EXTENDED_MODE_SEL]} + 3'h2);
      end else if (bank_control_reg[cur_bank][`BCR_MTYP] == `MTYP_NOR) begin
         cur_mode = MODE_2;
      end else begin
         cur_mode = MODE_1;
      end
   end

   // Configuration registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) begin
            bank_control_reg[i] <= `BCR_RESET;
            bank_timing_reg[i] <= `BTR_RESET;
            bank_write_timing_reg[i] <= `BTR_RESET;
         end
      end else if (clk_en && reg_wr) begin
         for (int i = 0; i < 4; i++) begin
            if (reg_addr == `REG_BCR_BASE + 6'(i) * `REG_BANK_STRIDE) begin
               bank_control_reg[i] <= reg_wdata & `BCR_WMASK;
            end
            if (reg_addr == `REG_BTR_BASE + 6'(i) * `REG_BANK_STRIDE) begin
               bank_timing_reg[i] <= reg_wdata & `BTR_WMASK;
            end
            if (reg_addr == `REG_BWTR_BASE + 6'(i) * `REG_BWTR_STRIDE) begin
               bank_write_timing_reg[i] <= reg_wdata & `BTR_WMASK;
            end
         end
      end
   end

   // Sticky refusal flag: a new refusal wins over a clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         err_flag <= 1'b0;
      end else if (clk_en) begin
         if (accept && !req_ok) begin
            err_flag <= 1'b1;
         end else if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`STAT_ERR]) begin
            err_flag <= 1'b0;
         end
      end
   end

   // Read port, data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            for (int i = 0; i < 4; i++) begin
               if (reg_addr == `REG_BCR_BASE + 6'(i) * `REG_BANK_STRIDE) begin
                  reg_rdata <= bank_control_reg[i];
               end
               if (reg_addr == `REG_BTR_BASE + 6'(i) * `REG_BANK_STRIDE) begin
                  reg_rdata <= bank_timing_reg[i];
               end
               if (reg_addr == `REG_BWTR_BASE + 6'(i) * `REG_BWTR_STRIDE) begin
                  reg_rdata <= bank_write_timing_reg[i];
               end
            end
            if (reg_addr == `REG_STATUS) begin
               reg_rdata[`STAT_BUSY] <= !host_ready;
               reg_rdata[`STAT_ERR] <= err_flag;
               reg_rdata[`STAT_MODE] <= cur_mode;
            end
         end
      end
   end
endmodule : static_mem_ctrl

// ### verilog/smc_defines.svh
// Register offsets, field positions, reset values and codes of the static memory controller
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define REG_ADDR_W 6
`define REG_BCR_BASE 6'h00
`define REG_BTR_BASE 6'h04
`define REG_BANK_STRIDE 6'h08
`define REG_BWTR_BASE 6'h20
`define REG_BWTR_STRIDE 6'h04
`define REG_STATUS 6'h30
`define BCR_RESET 32'h0000_1080
`define BTR_RESET 32'h0FFF_FFFF
`define BCR_WMASK 32'h000F_FFFF
`define BTR_WMASK 32'h3FFF_FFFF
`define BCR_BANK_EN 0
`define BCR_MTYP 3:2
`define BCR_BURST_RD 8
`define BCR_WAIT_POL 9
`define BCR_WRITE_ALLOW 12
`define BCR_EXT_EN 14
`define BCR_ASYNC_WAIT 15
`define BCR_SYNC_WR 19
`define BTR_ADDR_PHASE_LEN 3:0
`define BTR_DATA_PHASE_LEN 15:8
`define BTR_TURNAROUND_LEN 19:16
`define BTR_MEM_CLOCK_DIVIDER 23:20
`define BTR_BURST_FIRST_DATA_LATENCY 27:24
`define BTR_EXTENDED_MODE_SEL 29:28
`define MTYP_SRAM 2'h0
`define MTYP_PSRAM 2'h1
`define MTYP_NOR 2'h2
`define BURST_FIRST_DATA_LATENCY_BASE 8'h02
`define MEM_CLOCK_DIVIDER_MIN 4'h1
`define STAT_BUSY 0
`define STAT_ERR 1
`define STAT_MODE 4:2
`endif

// ### verilog/smc_pkg.sv
// Types shared by the static memory controller modules
package smc_pkg;
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_HALF = 2'h1,
      SIZE_WORD = 2'h2
   } size_t;
   typedef enum logic [2:0] {
      MODE_1 = 3'h0,
      MODE_2 = 3'h1,
      MODE_A = 3'h2,
      MODE_B = 3'h3,
      MODE_C = 3'h4,
      MODE_D = 3'h5
   } access_mode_t;
   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_ADDR = 8'h02,
      S_DATA = 8'h04,
      S_HOLD = 8'h08,
      S_SYNC_WAIT = 8'h10,
      S_SYNC = 8'h20,
      S_TURN = 8'h40,
      S_DONE = 8'h80
   } state_t;
endpackage : smc_pkg

// ### verilog/mem_clk_if.sv
// Divided memory clock and its edge markers between controller and divider
`timescale 1ns/10ps
interface mem_clk_if;
   logic [4:0] ratio;
   logic run;
   logic mem_clk;
   logic fall;
   logic rise;
   modport gen (input ratio, input run, output mem_clk, output fall, output rise);
   modport user (output ratio, output run, input mem_clk, input fall, input rise);
endinterface : mem_clk_if

// ### verilog/smc_clock_div.sv
// Memory clock divider with edge markers for the next clock edge
`timescale 1ns/10ps
module smc_clock_div (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   // Divided clock
   mem_clk_if.gen mc
);
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic next_clk;

   // Next phase count and clock level; idle clock stays low
   always_comb begin
      next_cnt = 5'h00;
      if (mc.run) begin
         next_cnt = (cnt == mc.ratio - 5'h01) ? 5'h00 : cnt + 5'h01;
      end
      next_clk = mc.run && (next_cnt < (mc.ratio >> 1));
   end

   // Phase counter and clock flop
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 5'h00;
         mc.mem_clk <= 1'b0;
      end else if (clk_en) begin
         cnt <= next_cnt;
         mc.mem_clk <= next_clk;
      end
   end

   // Markers: the coming edge makes the memory clock fall or rise
   assign mc.fall = clk_en && mc.mem_clk && !next_clk;
   assign mc.rise = clk_en && !mc.mem_clk && next_clk;
endmodule : smc_clock_div

// ### verilog/smc_access_check.sv
// Decides whether a host transaction is in the supported set
`timescale 1ns/10ps
`include "smc_defines.svh"
module smc_access_check
   import smc_pkg::*;
(
   // Bank configuration
   input wire logic [1:0] mem_type,
   input wire logic bank_en,
   input wire logic write_en,
   // Transaction
   input wire logic sync,
   input wire logic write,
   input wire size_t size,
   // Verdict
   output logic allowed
);
   // Table of allowed transactions per memory type and mode
   always_comb begin
      allowed = bank_en && !(write && !write_en) && (size != 2'h3);
      if (mem_type == `MTYP_NOR) begin
         if (!sync && write && size == SIZE_BYTE) allowed = 1'b0;
         if (sync && !write && size == SIZE_BYTE) allowed = 1'b0;
         if (sync && write) allowed = 1'b0;
      end else if (mem_type == `MTYP_PSRAM) begin
         if (sync && !write && size == SIZE_BYTE) allowed = 1'b0;
      end else if (sync) begin
         allowed = 1'b0;
      end
   end
endmodule : smc_access_check

// ### verification/mem_model.sv
// Behavioural 16-bit static memory on the controller pins
`timescale 1ns/10ps
module mem_model (
   // Clock
   input wire logic clock,
   // Controller pins
   input wire logic [25:0] mem_addr,
   input wire logic [15:0] mem_data_out,
   input wire logic mem_data_oe,
   input wire logic [3:0] bank_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [1:0] byte_lane_en_n,
   // Memory outputs
   output logic [15:0] mem_data_in,
   output logic mem_wait
);
   logic [15:0] mem [0:255];
   logic [15:0] last = 16'hA5C3;
   wire logic rd;
   wire logic [7:0] wa;
   // Read drive; released bus shows inverse of last value
   assign rd = ~&bank_select_n & ~read_strobe_n;
   assign wa = mem_addr[7:0];
   assign mem_data_in = rd ? mem[wa] : ~last;
   assign mem_wait = 1'b0;
   // Lane-wise write and last driven value
   always @(posedge clock) begin
      if (~&bank_select_n && !write_strobe_n && mem_data_oe) begin
         if (!byte_lane_en_n[0]) mem[wa][7:0] <= mem_data_out[7:0];
         if (!byte_lane_en_n[1]) mem[wa][15:8] <= mem_data_out[15:8];
      end
      if (rd) last <= mem[wa];
   end
endmodule : mem_model

// ### verification/static_mem_ctrl_sva.sv
// Pin timing checks for the static memory controller
`timescale 1ns/10ps
module static_mem_ctrl_sva #(
   parameter int ADDR_W = 26
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Host side
   input wire logic host_ready,
   input wire logic host_done,
   input wire logic host_error,
   // Memory side
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [15:0] mem_data_out,
   input wire logic mem_data_oe,
   input wire logic [3:0] bank_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [1:0] byte_lane_en_n,
   input wire logic memory_clock_out
);
   wire logic sel;
   // Any bank selected
   assign sel = ~&bank_select_n;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_clk; $fell(read_strobe_n) || $fell(write_strobe_n) |-> !memory_clock_out; endproperty
   a_clk: assert property (p_clk) else $error("clock high at strobe fall");
   property p_one_bank; $onehot0(~bank_select_n); endproperty
   a_one_bank: assert property (p_one_bank) else $error("two banks selected");
   property p_rd_lanes; !read_strobe_n |-> byte_lane_en_n == 2'b00; endproperty
   a_rd_lanes: assert property (p_rd_lanes) else $error("lane high in read");
   property p_wr_hold;
      $rose(write_strobe_n) |-> sel && mem_data_oe && $stable(mem_addr) ##1 !sel;
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write hold cycle wrong");
   property p_rd_len; $fell(read_strobe_n) |-> !read_strobe_n [*4] ##1 read_strobe_n; endproperty
   a_rd_len: assert property (p_rd_len) else $error("read phase length");
   property p_wr_len; $fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n; endproperty
   a_wr_len: assert property (p_wr_len) else $error("write phase length");
   property p_setup;
      $rose(sel) |-> read_strobe_n && write_strobe_n ##1 !(read_strobe_n && write_strobe_n);
   endproperty
   a_setup: assert property (p_setup) else $error("address phase length");
   property p_turn; $fell(sel) |-> !sel [*2]; endproperty
   a_turn: assert property (p_turn) else $error("turnaround too short");
   property p_busy; sel |-> !host_ready; endproperty
   a_busy: assert property (p_busy) else $error("ready during access");
   property p_refuse; host_done && host_error |-> !sel && $past(!sel); endproperty
   a_refuse: assert property (p_refuse) else $error("refused access selected");
   property p_page; !read_strobe_n && $past(!read_strobe_n) |-> $stable(mem_addr); endproperty
   a_page: assert property (p_page) else $error("address moved in read");
endmodule : static_mem_ctrl_sva
bind static_mem_ctrl static_mem_ctrl_sva #(.ADDR_W(ADDR_W)) static_mem_ctrl_sva_i (
   .clock, .rst_b, .host_ready, .host_done, .host_error, .mem_addr, .mem_data_out,
   .mem_data_oe, .bank_select_n, .read_strobe_n, .write_strobe_n, .byte_lane_en_n,
   .memory_clock_out
);

// ### verification/static_mem_ctrl_tb.sv
// Self-checking bench for the static memory controller
`timescale 1ns/10ps
module static_mem_ctrl_tb;
   import smc_pkg::*;
   logic clock = 0;
   logic rst_b = 0;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic host_req = 0;
   logic host_write = 0;
   logic [5:0] reg_addr = 6'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] host_wdata = 32'h0;
   logic [28:0] host_addr = 29'h0;
   size_t host_size = SIZE_BYTE;
   logic [31:0] reg_rdata, host_rdata, d;
   logic host_ready, host_done, host_error, mem_data_oe, mem_wait;
   logic [25:0] mem_addr;
   logic [15:0] mem_data_out, mem_data_in;
   logic [3:0] bank_select_n;
   logic read_strobe_n, write_strobe_n, addr_latch_n, memory_clock_out;
   logic [1:0] byte_lane_en_n;
   logic [64:0] hq[$];
   logic [64:0] e;
   logic [31:0] rq[$];
   logic rd_seen = 0;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   // Clock
   always #5 clock = ~clock;
   static_mem_ctrl static_mem_ctrl_i (
      .clock, .rst_b, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .host_req, .host_write, .host_size, .host_addr, .host_wdata, .host_ready, .host_done,
      .host_error, .host_rdata, .mem_addr, .mem_data_out, .mem_data_oe, .mem_data_in,
      .mem_wait, .bank_select_n, .read_strobe_n, .write_strobe_n, .addr_latch_n,
      .byte_lane_en_n, .memory_clock_out
   );
   mem_model mem_model_i (
      .clock, .mem_addr, .mem_data_out, .mem_data_oe, .bank_select_n, .read_strobe_n,
      .write_strobe_n, .byte_lane_en_n, .mem_data_in, .mem_wait
   );
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // Register access; a read notes its expected data
   task automatic rw(input logic [5:0] a, input logic [31:0] wd, input logic w,
                     input logic [31:0] x);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= wd;
      reg_wr <= w;
      reg_rd <= !w;
      if (!w) rq.push_back(x);
      @(posedge clock);
      reg_wr <= 0;
      reg_rd <= 0;
   endtask : rw
   // Host request when idle; notes error, data mask and data
   task automatic ht(input logic w, input size_t s, input logic [28:0] a,
                     input logic [31:0] wd, input logic er, input logic [31:0] m,
                     input logic [31:0] x);
      do @(negedge clock); while (host_ready !== 1'b1);
      @(posedge clock);
      host_req <= 1;
      host_write <= w;
      host_size <= s;
      host_addr <= a;
      host_wdata <= wd;
      hq.push_back({er, m, x});
      @(posedge clock);
      host_req <= 0;
   endtask : ht
   // Result watcher against the oldest note
   always @(negedge clock) begin
      if (rd_seen) cmp("reg_rdata", rq.pop_front(), reg_rdata);
      rd_seen = reg_rd;
      if (host_done === 1'b1) begin
         e = hq.pop_front();
         cmp("host_error", {31'h0, e[64]}, {31'h0, host_error});
         cmp("host_rdata", e[63:32] & e[31:0], e[63:32] & host_rdata);
      end
   end
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   // Main sequence
   initial begin
      d = $urandom(32'hEE4F);
      d = $urandom;
      repeat (12) @(posedge clock);
      rst_b <= 1;
      rw(6'h00, 32'h0, 0, 32'h0000_1080);
      rw(6'h04, 32'h0, 0, 32'h0FFF_FFFF);
      rw(6'h3C, 32'hFFFF_FFFF, 1, 32'h0);
      rw(6'h3C, 32'h0, 0, 32'h0);
      rw(6'h00, 32'h0000_1081, 1, 32'h0);
      rw(6'h04, 32'h0002_0401, 1, 32'h0);
      rw(6'h20, 32'h0002_0401, 1, 32'h0);
      rw(6'h10, 32'h0000_1089, 1, 32'h0);
      rw(6'h18, 32'h0008_1089, 1, 32'h0);
      rw(6'h00, 32'h0, 0, 32'h0000_1081);
      ht(1, SIZE_WORD, 29'h10, d, 0, 32'h0, 32'h0);
      ht(1, SIZE_BYTE, 29'h11, 32'hAB, 0, 32'h0, 32'h0);
      ht(0, SIZE_WORD, 29'h10, 32'h0, 0, 32'hFFFF_FFFF, {d[31:16], 8'hAB, d[7:0]});
      ht(0, SIZE_HALF, 29'h12, 32'h0, 0, 32'hFFFF, {16'h0, d[31:16]});
      ht(0, SIZE_BYTE, 29'h11, 32'h0, 0, 32'hFF, 32'hAB);
      ht(0, SIZE_HALF, 29'h0800_0000, 32'h0, 1, 32'h0, 32'h0);
      ht(1, SIZE_BYTE, 29'h1000_0000, 32'h5, 1, 32'h0, 32'h0);
      ht(1, SIZE_HALF, 29'h1800_0000, 32'h5, 1, 32'h0, 32'h0);
      ht(1, size_t'(2'h3), 29'h10, 32'h0, 1, 32'h0, 32'h0);
      rw(6'h30, 32'h0, 0, 32'h2);
      rw(6'h30, 32'h2, 1, 32'h0);
      rw(6'h30, 32'h0, 0, 32'h0);
      while (hq.size() != 0 || rq.size() != 0) @(negedge clock);
      wrap_up();
   end
endmodule : static_mem_ctrl_tb
